// file: hdl/seerp_pkg.sv
// shared constants, types and helpers of the serial eeprom read and poll block
package seerp_pkg;
   localparam int SEERP_PTR_W = 13;
   localparam int SEERP_DEPTH_DEF = 8192;
   // device type code: arbitrary neutral value
   localparam logic [3:0] SEERP_TYPE_CODE = 4'h6;
   localparam logic [3:0] SEERP_BITS_BYTE = 4'h8;
   // positions inside the address byte and the word address
   localparam int SEERP_TYPE_LSB = 4;
   localparam int SEERP_SEL_LSB = 1;
   localparam int SEERP_RW_BIT = 0;
   localparam int SEERP_HI_LSB = 8;
   localparam int SEERP_CLK_NS = 50;
   localparam int SEERP_TWR_US = 5000;
   // longest time, so the division rounds down
   localparam int SEERP_TWR_CYC = SEERP_TWR_US * 1000 / SEERP_CLK_NS;
   localparam int SEERP_CNT_W = 32;

   typedef enum logic [3:0] {ST_IDLE, ST_DEV, ST_WHI, ST_WLO, ST_WDAT, ST_ACK, ST_TX, ST_MACK} seerp_state_t;

   typedef struct packed {
      logic done_tgl;
      logic rst_n;
      logic [2:0] cs;
      logic sda;
      logic scl;
   } seerp_pins_t;

   typedef struct packed {
      seerp_pins_t s1;
      seerp_pins_t s2;
   } seerp_sync_t;

   typedef struct packed {
      seerp_state_t st;
      seerp_state_t nxt;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [SEERP_PTR_W-1:0] ptr;
      logic wrote;
      logic mack;
      logic req_tgl;
      logic sda_oe_n;
      logic sda_o;
      logic scl_q;
      logic sda_q;
   } seerp_link_t;

   typedef struct packed {
      logic r1;
      logic r2;
      logic r3;
      logic busy;
      logic done_tgl;
      logic [SEERP_CNT_W-1:0] cnt;
   } seerp_timer_t;

   function automatic logic [SEERP_PTR_W-1:0] seerp_next_ptr(input logic [SEERP_PTR_W-1:0] p, input int depth);
      if (int'(p) >= depth - 1) begin
         return '0;
      end
      return p + 13'h1;
   endfunction : seerp_next_ptr

   function automatic logic [SEERP_PTR_W-1:0] seerp_mask_ptr(input logic [SEERP_PTR_W-1:0] p, input int depth);
      logic [SEERP_PTR_W-1:0] m;
      m = SEERP_PTR_W'(depth - 1);
      return p & m;
   endfunction : seerp_mask_ptr
endpackage : seerp_pkg

// file: hdl/seerp_sync.sv
// two-flop synchroniser for the pins and levels entering the link domain
`timescale 1ns/100ps
module seerp_sync
   import seerp_pkg::*;
(
   input wire logic clk,
   input seerp_pins_t d,
   output seerp_pins_t q
);
   seerp_sync_t s;
   seerp_sync_t n;

   always_comb begin
      n.s1 = d;
      n.s2 = s.s1;
   end

   always_ff @(posedge clk) begin
      s <= n;
   end

   assign q = s.s2;
endmodule : seerp_sync

// file: hdl/seerp_prog_timer.sv
// self-timed programming cycle, runs on the reference clock
`timescale 1ns/100ps
module seerp_prog_timer
   import seerp_pkg::*;
#(
   parameter int TWR_CYC = SEERP_TWR_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_tgl,
   output logic done_tgl,
   output logic busy
);
   seerp_timer_t s;
   seerp_timer_t n;

   always_comb begin
      n = s;
      n.r1 = req_tgl;
      n.r2 = s.r1;
      n.r3 = s.r2;
      if (s.busy) begin
         if (s.cnt == SEERP_CNT_W'(TWR_CYC - 1)) begin
            n.busy = 1'b0;
            n.done_tgl = s.r3;
         end else begin
            n.cnt = s.cnt + 32'h1;
         end
      end else if (s.r2 != s.r3) begin
         // see (RULE1)
         n.busy = 1'b1;
         n.cnt = '0;
      end
      if (!rst_n) begin
         n = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      s <= n;
   end

   assign done_tgl = s.done_tgl;
   assign busy = s.busy;

   property p_twr_len;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.busy && s.cnt < SEERP_CNT_W'(TWR_CYC - 1)) |=> s.busy;
   endproperty
   a_twr_len: assert property (p_twr_len) else $error("programming cycle ended early"); // see (RULE21)
endmodule : seerp_prog_timer

// file: hdl/seerp_top.sv
// two-wire serial eeprom slave: address match, busy polling and reads
// Notes on behaviour
// (RULE1) a stop after written data bytes starts the self-timed programming cycle
// (RULE2) the master may poll right after stop with start and write address
// (RULE3) while programming, the address byte is not acknowledged
// (RULE4) once programming is done, polling is acknowledged and traffic resumes
// (RULE5) a read is requested by the address byte with direction bit one
// (RULE6) the address counter holds last accessed location plus one
// (RULE7) a read address without word address returns the byte at the counter
// (RULE8) after a master no-acknowledge and stop, the data line is released
// (RULE9) after the last array byte, a current read returns location zero
// (RULE10) a random read starts with a dummy write of the word address
// (RULE11) after repeated start and read address, the loaded address is returned
// (RULE12) a single random read ends with no acknowledge then stop
// (RULE13) sequential reads begin as current or random reads, continued by acks
// (RULE14) each master acknowledge makes the device send the next byte
// (RULE15) the master ends sequential reads with high ack slot then stop
// (RULE16) the counter advances by one for every byte sent
// (RULE17) past the top address the counter wraps to zero and output continues
// (RULE18) only an address with matching type code and select pins is acknowledged
// (RULE19) the master sends the word address as two bytes after the write address
// (RULE20) an acknowledge pulls the data line low during the ninth clock
// (RULE21) programming duration is a parameter within the maximum write cycle time
// (RULE22) array depth is a parameter so one block covers both densities
`timescale 1ns/100ps
module seerp_top
   import seerp_pkg::*;
#(
   parameter int MEM_DEPTH = SEERP_DEPTH_DEF,
   parameter int TWR_CYC = SEERP_TWR_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic [2:0] chip_select_pins,
   output logic [SEERP_PTR_W-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic prog_busy
);
   seerp_pins_t raw;
   seerp_pins_t sy;
   seerp_link_t s;
   seerp_link_t n;
   logic done_tgl;
   logic lrst_n;
   logic fall;
   logic rise;
   logic start;
   logic stop;
   logic byte_end;
   logic match;
   logic busy_l;
   logic do_load;
   logic do_ack;
   logic [SEERP_PTR_W-1:0] nptr;

   // everything the link logic reads from outside except mem_rdata passes two flops first
   assign raw.done_tgl = done_tgl;
   assign raw.rst_n = rst_n;
   assign raw.cs = chip_select_pins;
   assign raw.sda = sda_i;
   assign raw.scl = scl_i;

   seerp_sync u_sync (
      .clk(link_clk),
      .d(raw),
      .q(sy)
   );

   seerp_prog_timer #(
      .TWR_CYC(TWR_CYC)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .req_tgl(s.req_tgl),
      .done_tgl(done_tgl),
      .busy(prog_busy)
   );

   assign lrst_n = sy.rst_n;
   assign fall = s.scl_q & ~sy.scl;
   assign rise = ~s.scl_q & sy.scl;
   // data edges while the clock stays high frame a transfer
   assign start = sy.scl & s.scl_q & s.sda_q & ~sy.sda;
   assign stop = sy.scl & s.scl_q & ~s.sda_q & sy.sda;
   assign byte_end = (s.cnt == SEERP_BITS_BYTE);
   assign match = (s.shreg[SEERP_TYPE_LSB +: 4] == SEERP_TYPE_CODE) && (s.shreg[SEERP_SEL_LSB +: 3] == sy.cs);
   // request and completion toggles differ while the array is programming
   assign busy_l = (s.req_tgl != sy.done_tgl);
   assign nptr = seerp_next_ptr(s.ptr, MEM_DEPTH);

   always_comb begin
      n = s;
      do_load = 1'b0;
      do_ack = 1'b0;
      n.scl_q = sy.scl;
      n.sda_q = sy.sda;
      n.sda_o = 1'b0;
      if (start) begin
         n.st = ST_DEV;
         n.cnt = '0;
         n.sda_oe_n = 1'b1;
         n.wrote = 1'b0;
      end else if (stop) begin
         if (s.wrote) begin
            n.req_tgl = ~s.req_tgl; // see (RULE1)
         end
         n.wrote = 1'b0;
         n.st = ST_IDLE;
         n.sda_oe_n = 1'b1; // see (RULE8)
      end else begin
         if (rise) begin
            case (s.st)
               ST_DEV, ST_WHI, ST_WLO, ST_WDAT: begin
                  n.shreg = {s.shreg[6:0], sy.sda};
                  n.cnt = s.cnt + 4'h1;
               end
               ST_TX: begin
                  n.cnt = s.cnt + 4'h1;
               end
               ST_MACK: begin
                  n.mack = ~sy.sda;
               end
               default: begin
               end
            endcase
         end
         if (fall) begin
            case (s.st)
               ST_DEV: begin
                  if (byte_end) begin
                     if (match && !busy_l) begin // see (RULE18) see (RULE4)
                        do_ack = 1'b1;
                        n.nxt = s.shreg[SEERP_RW_BIT] ? ST_TX : ST_WHI; // see (RULE7) see (RULE11)
                     end else begin
                        n.st = ST_IDLE; // see (RULE3)
                     end
                  end
               end
               ST_WHI: begin
                  if (byte_end) begin
                     n.ptr[SEERP_PTR_W-1:SEERP_HI_LSB] = s.shreg[SEERP_PTR_W-SEERP_HI_LSB-1:0];
                     do_ack = 1'b1;
                     n.nxt = ST_WLO;
                  end
               end
               ST_WLO: begin
                  if (byte_end) begin
                     n.ptr = seerp_mask_ptr({s.ptr[SEERP_PTR_W-1:SEERP_HI_LSB], s.shreg}, MEM_DEPTH); // see (RULE22)
                     do_ack = 1'b1;
                     n.nxt = ST_WDAT;
                  end
               end
               ST_WDAT: begin
                  if (byte_end) begin
                     n.ptr = nptr; // see (RULE6)
                     n.wrote = 1'b1;
                     do_ack = 1'b1;
                     n.nxt = ST_WDAT;
                  end
               end
               ST_ACK: begin
                  n.sda_oe_n = 1'b1;
                  n.cnt = '0;
                  n.st = s.nxt;
                  do_load = (s.nxt == ST_TX);
               end
               ST_TX: begin
                  if (byte_end) begin
                     n.sda_oe_n = 1'b1;
                     n.st = ST_MACK;
                  end else begin
                     n.sda_oe_n = s.shreg[7];
                     n.shreg = {s.shreg[6:0], 1'b0};
                  end
               end
               ST_MACK: begin
                  if (s.mack) begin
                     do_load = 1'b1; // see (RULE14)
                  end else begin
                     n.sda_oe_n = 1'b1; // see (RULE8)
                     n.st = ST_IDLE;
                  end
               end
               default: begin
               end
            endcase
            if (do_ack) begin
               n.sda_oe_n = 1'b0; // see (RULE20)
               n.st = ST_ACK;
            end
            if (do_load) begin
               n.st = ST_TX;
               n.cnt = '0;
               n.sda_oe_n = mem_rdata[7]; // see (RULE7)
               n.shreg = {mem_rdata[6:0], 1'b0};
               n.ptr = nptr; // see (RULE16) see (RULE17) see (RULE9)
               n.mack = 1'b0;
            end
         end
      end
      if (!lrst_n) begin
         n = '0;
         n.sda_oe_n = 1'b1;
         // idle bus levels, so no false edge follows reset
         n.scl_q = 1'b1;
         n.sda_q = 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      s <= n;
   end

   assign sda_o = s.sda_o;
   assign sda_oe_n = s.sda_oe_n;
   assign mem_addr = s.ptr;

   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!lrst_n);

   sequence s_dev_end;
      s.st == ST_DEV && fall && byte_end && !start && !stop;
   endsequence

   sequence s_calm;
      !start && !stop;
   endsequence

   sequence s_tx_fall;
      s.st == ST_TX && fall && !start && !stop;
   endsequence

   sequence s_mack_fall;
      s.st == ST_MACK && fall && !start && !stop;
   endsequence

   property p_prog_start;
      (stop && s.wrote) |=> (s.req_tgl != $past(s.req_tgl)) && busy_l;
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("stop after write did not start programming"); // see (RULE1)

   property p_busy_nak;
      s_dev_end ##0 busy_l |=> s.sda_oe_n && s.st == ST_IDLE;
   endproperty
   a_busy_nak: assert property (p_busy_nak) else $error("address acknowledged while programming"); // see (RULE3)

   property p_ready_ack;
      s_dev_end ##0 (match && !busy_l) |=> !s.sda_oe_n && s.st == ST_ACK;
   endproperty
   a_ready_ack: assert property (p_ready_ack) else $error("matching address not acknowledged"); // see (RULE4)

   property p_foreign_nak;
      s_dev_end ##0 !match |=> s.sda_oe_n && s.st == ST_IDLE;
   endproperty
   a_foreign_nak: assert property (p_foreign_nak) else $error("foreign address acknowledged"); // see (RULE18)

   property p_read_dir;
      s_dev_end ##0 (match && !busy_l && s.shreg[0]) |=> s.nxt == ST_TX ##0 s.st == ST_ACK;
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("read address did not lead to data out"); // see (RULE7)

   property p_ack_hold;
      (s.st == ST_ACK && !fall) ##0 s_calm |=> s.st == ST_ACK && !s.sda_oe_n;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("acknowledge released before clock fall"); // see (RULE20)

   property p_load_ptr;
      do_load |=> s.ptr == $past(nptr) && s.st == ST_TX && s.cnt == 4'h0;
   endproperty
   a_load_ptr: assert property (p_load_ptr) else $error("counter not advanced on byte out"); // see (RULE16)

   property p_wrap;
      (do_load && int'(s.ptr) == MEM_DEPTH - 1) |=> s.ptr == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap at top"); // see (RULE17)

   property p_first_bit;
      do_load |=> s.sda_oe_n == $past(mem_rdata[7]);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first data bit wrong"); // see (RULE14)

   property p_nack_release;
      (s.st == ST_MACK && fall && !s.mack) ##0 s_calm |=> s.sda_oe_n && s.st == ST_IDLE;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("data line held after no-acknowledge"); // see (RULE8)

   property p_waddr;
      (s.st == ST_WLO && fall && byte_end) ##0 s_calm |=> s.ptr[SEERP_HI_LSB-1:0] == $past(s.shreg) ##0 s.nxt == ST_WDAT;
   endproperty
   a_waddr: assert property (p_waddr) else $error("word address not loaded"); // see (RULE11)

   property p_tx_shift;
      s_tx_fall ##0 !byte_end |=> s.sda_oe_n == $past(s.shreg[7]) && s.st == ST_TX;
   endproperty
   a_tx_shift: assert property (p_tx_shift) else $error("data bit not shifted out"); // see (RULE14)

   property p_tx_done;
      s_tx_fall ##0 byte_end |=> s.sda_oe_n && s.st == ST_MACK;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("line not released for master acknowledge"); // see (RULE14)

   property p_mack_more;
      s_mack_fall ##0 s.mack |-> do_load;
   endproperty
   a_mack_more: assert property (p_mack_more) else $error("next byte not loaded after acknowledge"); // see (RULE14)

   property p_stop_idle;
      stop |=> s.st == ST_IDLE && s.sda_oe_n;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("line held after stop"); // see (RULE8)

   property p_dummy_quiet;
      (stop && !s.wrote) |=> s.req_tgl == $past(s.req_tgl);
   endproperty
   a_dummy_quiet: assert property (p_dummy_quiet) else $error("programming started without data"); // see (RULE1)

   property p_start_dev;
      start |=> s.st == ST_DEV && s.cnt == 4'h0 && s.sda_oe_n && !s.wrote;
   endproperty
   a_start_dev: assert property (p_start_dev) else $error("start did not restart addressing"); // see (RULE11)

   property p_ack_next;
      (s.st == ST_ACK && fall) ##0 s_calm |=> s.st == $past(s.nxt) && s.cnt == 4'h0 && (s.sda_oe_n || s.st == ST_TX);
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("acknowledge not ended at ninth clock fall"); // see (RULE20)

   property p_wdat_count;
      (s.st == ST_WDAT && fall && byte_end) ##0 s_calm |=> s.ptr == $past(nptr) && s.wrote && !s.sda_oe_n;
   endproperty
   a_wdat_count: assert property (p_wdat_count) else $error("counter not advanced on data byte"); // see (RULE6)

   property p_whi_load;
      (s.st == ST_WHI && fall && byte_end) ##0 s_calm |=>
         s.ptr[SEERP_PTR_W-1:SEERP_HI_LSB] == $past(s.shreg[SEERP_PTR_W-SEERP_HI_LSB-1:0]) ##0 s.nxt == ST_WLO;
   endproperty
   a_whi_load: assert property (p_whi_load) else $error("word address high byte not loaded"); // see (RULE11)

   property p_ptr_range;
      s.st == ST_TX |-> int'(s.ptr) < MEM_DEPTH;
   endproperty
   a_ptr_range: assert property (p_ptr_range) else $error("counter beyond array depth"); // see (RULE22)

   property p_tx_steady;
      s.st == ST_TX |=> $stable(s.ptr);
   endproperty
   a_tx_steady: assert property (p_tx_steady) else $error("counter moved inside a byte"); // see (RULE16)
endmodule : seerp_top

// file: test/seerp_master_model.sv
// two-wire bus master model: drives the bus clock and pulls the data line low
`timescale 1ns/100ps
module seerp_master_model
(
   input wire logic ref_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   output logic res_valid,
   output logic [8:0] res_val
);
   // one bus clock phase in reference cycles, well above four link cycles
   localparam int H = 12;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      res_valid = 1'b0;
      res_val = 9'h000;
   end
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : w
   task automatic post(input logic [8:0] v);
      res_val <= v;
      res_valid <= 1'b1;
      w(1);
      res_valid <= 1'b0;
   endtask : post
   // from an idle bus; leaves the clock low
   task automatic start_c();
      sda_low <= 1'b1;
      w(H);
      scl <= 1'b0;
      w(H);
   endtask : start_c
   task automatic rstart_c();
      sda_low <= 1'b0;
      w(H);
      scl <= 1'b1;
      w(H);
      start_c();
   endtask : rstart_c
   task automatic stop_c();
      sda_low <= 1'b1;
      w(H);
      scl <= 1'b1;
      w(H);
      sda_low <= 1'b0;
      w(H);
   endtask : stop_c
   // data moves only while the clock is low, a few cycles after its fall
   task automatic bit_c(input logic b, output logic seen);
      sda_low <= !b;
      w(H);
      scl <= 1'b1;
      w(H / 2);
      seen = sda;
      w(H / 2);
      scl <= 1'b0;
      w(3);
   endtask : bit_c
   task automatic send(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_c(b[i], s);
      bit_c(1'b1, s);
      post({1'b0, 7'h00, !s});
   endtask : send
   // a low ack asks for the next byte, a high one ends the read
   task automatic recv(input logic mack);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, s);
         d[i] = s;
      end
      bit_c(!mack, s);
      post({1'b1, d});
   endtask : recv
endmodule : seerp_master_model

// file: test/tb_top.sv
// self-checking bench of the serial eeprom read and poll block
`timescale 1ns/100ps
module tb_top;
   import seerp_pkg::*;
   localparam int DEPTH = 4096;
   localparam int LIMIT = 20000;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] cs;
   logic scl, sda_low, sda, sda_o, sda_oe_n, prog_busy, res_valid;
   logic [8:0] res_val;
   logic [SEERP_PTR_W-1:0] mem_addr;
   logic [7:0] mem_rdata;
   logic [8:0] q[$];
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   always #25 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end
   // wired-and data line with pull-up
   assign sda = !sda_low && (sda_oe_n || sda_o);
   assign mem_rdata = mem_addr[7:0] ^ {3'h0, mem_addr[12:8]};
   seerp_top #(.MEM_DEPTH(DEPTH), .TWR_CYC(600)) seerp_top_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .chip_select_pins(cs), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .prog_busy(prog_busy));
   seerp_master_model mst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
      .res_valid(res_valid), .res_val(res_val));
   function automatic logic [7:0] mb(input int a);
      logic [12:0] m;
      m = 13'(a % DEPTH);
      return m[7:0] ^ {3'h0, m[12:8]};
   endfunction : mb
   function automatic logic [7:0] dev(input logic rw);
      return {SEERP_TYPE_CODE, cs, rw};
   endfunction : dev
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic report_and_stop();
      check("pending results", 16'(q.size()), 16'h0000);
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   task automatic tx(input logic [7:0] b, input logic ack);
      q.push_back({1'b0, 7'h00, ack});
      mst.send(b);
   endtask : tx
   task automatic rx(input int a, input logic mack);
      q.push_back({1'b1, mb(a)});
      mst.recv(mack);
   endtask : rx
   always @(posedge ref_clk) begin
      cyc++;
      if (res_valid === 1'b1) begin
         check("bus result", 16'(res_val), q.size() > 0 ? 16'(q.pop_front()) : 16'hffff);
      end
      if (cyc == LIMIT) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      int a;
      void'($urandom(9940));
      @(posedge ref_clk);
      cs <= 3'($urandom);
      repeat (9) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check("idle line", 16'(sda_oe_n), 16'h0001);
      check("counter after reset", 16'(mem_addr), 16'h0000);
      for (int k = 0; k < 2; k++) begin
         mst.start_c();
         tx(k ? {SEERP_TYPE_CODE, ~cs, 1'b0} : {~SEERP_TYPE_CODE, cs, 1'b1}, 1'b0);
         mst.stop_c();
      end
      for (int k = 0; k < 2; k++) begin
         a = k ? int'($urandom % DEPTH) : DEPTH - 2;
         mst.start_c();
         tx(dev(1'b0), 1'b1);
         tx(8'(a >> 8), 1'b1);
         tx(8'(a), 1'b1);
         mst.rstart_c();
         tx(dev(1'b1), 1'b1);
         for (int i = 0; i < 4; i++) rx(a + i, i < 3);
         mst.stop_c();
         check("released line", 16'(sda_oe_n), 16'h0001);
         check("dummy write idle", 16'(prog_busy), 16'h0000);
      end
      mst.start_c();
      tx(dev(1'b1), 1'b1);
      rx(a + 4, 1'b0);
      mst.stop_c();
      mst.start_c();
      tx(dev(1'b0), 1'b1);
      tx(8'h0f, 1'b1);
      tx(8'hff, 1'b1);
      tx(8'($urandom), 1'b1);
      mst.stop_c();
      mst.w(10);
      check("programming", 16'(prog_busy), 16'h0001);
      mst.start_c();
      tx(dev(1'b0), 1'b0);
      mst.stop_c();
      for (int i = 0; i < 2000 && prog_busy !== 1'b0; i++) mst.w(1);
      mst.w(10);
      mst.start_c();
      tx(dev(1'b0), 1'b1);
      mst.rstart_c();
      tx(dev(1'b1), 1'b1);
      rx(0, 1'b0);
      mst.stop_c();
      mst.w(5);
      report_and_stop();
   end
endmodule : tb_top
